// [pkg/srcc_pkg.sv]
// constants and types for the status, return and cycle counter unit
// assumes a 64-bit register file and a quadword read port to memory
package srcc_pkg;
    // ------------------------------------------------------------
    // data widths
    // ------------------------------------------------------------
    localparam int XLEN = 64;
    localparam int PS_W = 13;
    localparam int HALF_W = 32;
    localparam int MODES = 4;
    // ------------------------------------------------------------
    // status word fields
    // ------------------------------------------------------------
    localparam int SW_LSB = 0;
    localparam int SW_W = 2;
    localparam int CM_LSB = 3;
    localparam int CM_W = 2;
    localparam int ALIGN_LSB = 56;
    localparam int ALIGN_W = 6;
    localparam logic [PS_W-1:0] PS_RESET = 13'h0000;
    localparam logic [MODES-1:0] TE_RESET = 4'h0;
    localparam logic [CM_W-1:0] MODE_KERNEL = 2'h0;
    // ------------------------------------------------------------
    // frame layout on the stack
    // ------------------------------------------------------------
    localparam int POP_CNT = 8;
    localparam int GPR_CNT = 6;
    localparam logic [2:0] IDX_PC = 3'h6;
    localparam logic [2:0] IDX_PS = 3'h7;
    localparam logic [2:0] GPR_FIRST = 3'h2;
    localparam logic [2:0] GPR_RESULT = 3'h0;
    localparam logic [XLEN-1:0] QW_BYTES = 64'h8;
    localparam logic [XLEN-1:0] FRAME_BYTES = 64'h40;
    // ------------------------------------------------------------
    // operations and states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_READ_STATUS_OP = 3'h0,
        OP_REI = 3'h1,
        OP_READ_SYSTEM_CYCLES = 3'h2,
        OP_READ_PROCESS_CYCLES = 3'h3,
        OP_SWAP_TE = 3'h4,
        OP_WR_SW = 3'h5
    } srcc_op_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_POP = 3'h1,
        ST_CHECK = 3'h2,
        ST_WB = 3'h3,
        ST_DONE = 3'h4
    } srcc_state_t;
endpackage

// [src/srcc_cycle_counter.sv]
// 64-bit system cycle counter: free low half plus a wrap-driven upper half
// assumes sample pulses come from clock interrupts and counter reads
`timescale 1ns/100ps
module srcc_cycle_counter #(
    parameter int HW = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic sample,
    output logic [HW-1:0] lowCount,
    output logic [2*HW-1:0] fullCount
);
    logic [HW-1:0] lowReg, lowNext;
    logic [HW-1:0] highReg, highNext;
    logic [HW-1:0] seenReg, seenNext;
    logic [2*HW-1:0] lastReg;
    logic wrap;

    // a wrap not yet folded in is added on the fly so reads never go back
    assign wrap = lowReg < seenReg;
    assign lowCount = lowReg;
    assign fullCount = {highReg + HW'(wrap), lowReg};

    always_comb begin
        lowNext = lowReg + HW'(1);
        highNext = highReg;
        seenNext = seenReg;
        if (sample) begin
            highNext = highReg + HW'(wrap);
            seenNext = lowReg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lowReg <= '0;
            highReg <= '0;
            seenReg <= '0;
            lastReg <= '0;
        end else if (ce) begin
            lowReg <= lowNext;
            highReg <= highNext;
            seenReg <= seenNext;
            if (sample) begin
                lastReg <= fullCount;
            end
        end
    end

    AST_SCC_MONOTONIC: assert property (
        @(posedge clk) disable iff (rst)
        ce && sample |-> fullCount >= lastReg)
    else $error("system cycle count went backwards");
endmodule

// [src/srcc_mode_slots.sv]
// per-mode saved stack pointers, one slot for each processor mode
// assumes one write and one read per cycle; read is combinational
`timescale 1ns/100ps
module srcc_mode_slots #(
    parameter int W = 64,
    parameter int N = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wrEn,
    input wire logic [$clog2(N)-1:0] wrMode,
    input wire logic [W-1:0] wrData,
    input wire logic [$clog2(N)-1:0] rdMode,
    output logic [W-1:0] rdData
);
    logic [W-1:0] slotReg [N];
    logic [W-1:0] slotNext [N];

    assign rdData = slotReg[rdMode];

    always_comb begin
        for (int i = 0; i < N; i++) begin
            slotNext[i] = slotReg[i];
            if (wrEn && (wrMode == i[$clog2(N)-1:0])) begin
                slotNext[i] = wrData;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < N; i++) begin
                slotReg[i] <= '0;
            end
        end else if (ce) begin
            slotReg <= slotNext;
        end
    end
endmodule

// [src/srcc_status_unit.sv]
// status read, exception return, cycle reads, trap enable swap, sw field
// assumes memory answers each quadword read with memAck and memData
`timescale 1ns/100ps
module srcc_status_unit (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic opValid,
    input wire srcc_pkg::srcc_op_t opCode,
    input wire logic [63:0] r16,
    output logic opReady,
    output logic opDone,
    output logic illegalOperand,
    output logic gprWe,
    output logic [2:0] gprIdx,
    output logic [63:0] gprData,
    output logic pcLoad,
    output logic [63:0] pcOut,
    output logic [12:0] psOut,
    output logic [63:0] spOut,
    input wire logic spWe,
    input wire logic [63:0] spWdata,
    output logic memReq,
    output logic [63:0] memAddr,
    input wire logic memAck,
    input wire logic [63:0] memData,
    input wire logic intPending,
    input wire logic [3:0] astPending,
    output logic [3:0] trapEnOut,
    output logic intTake,
    output logic astTake,
    input wire logic lockSet,
    input wire logic handlerSet,
    output logic lockFlag,
    output logic handlerFlag,
    input wire logic clockIrq,
    input wire logic cycleReadDisable
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    srcc_pkg::srcc_state_t stateReg, stateNext;
    logic [2:0] popIdxReg, popIdxNext;
    logic [63:0] tmpReg [8];
    logic [63:0] tmpNext [8];
    logic [12:0] psReg, psNext;
    logic [63:0] spReg, spNext;
    logic [3:0] teReg, teNext;
    logic lockReg, lockNext, hdlReg, hdlNext;
    logic memReqReg, memReqNext;
    logic [63:0] memAddrReg, memAddrNext;
    logic gprWeReg, gprWeNext;
    logic [2:0] gprIdxReg, gprIdxNext;
    logic [63:0] gprDataReg, gprDataNext;
    logic pcLoadReg, pcLoadNext;
    logic [63:0] pcReg, pcNext;
    logic doneReg, doneNext, illReg, illNext;
    logic intTakeReg, intTakeNext, astTakeReg, astTakeNext;
    logic slotWe, sccRd;
    logic [1:0] curMode, newMode;
    logic [63:0] newPs, psChk, newSp, slotRd;
    logic [31:0] pccLow;
    logic [63:0] sccValue;
    logic badPs;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    srcc_cycle_counter #(
        .HW(srcc_pkg::HALF_W)
    ) u_counter (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .sample(clockIrq | sccRd),
        .lowCount(pccLow),
        .fullCount(sccValue)
    );

    srcc_mode_slots #(
        .W(srcc_pkg::XLEN),
        .N(srcc_pkg::MODES)
    ) u_slots (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .wrEn(slotWe),
        .wrMode(curMode),
        .wrData(newSp),
        .rdMode(newMode),
        .rdData(slotRd)
    );

    assign curMode = psReg[srcc_pkg::CM_LSB +: srcc_pkg::CM_W];
    assign newPs = tmpReg[srcc_pkg::IDX_PS];
    assign newMode = newPs[srcc_pkg::CM_LSB +: srcc_pkg::CM_W];

    // stray-bit check outside kernel mode: everything but mode, alignment and sw must be zero
    always_comb begin
        psChk = newPs;
        psChk[srcc_pkg::CM_LSB +: srcc_pkg::CM_W] = '0;
        psChk[srcc_pkg::ALIGN_LSB +: srcc_pkg::ALIGN_W] = '0;
        psChk[srcc_pkg::SW_LSB +: srcc_pkg::SW_W] = '0;
        badPs = (curMode != srcc_pkg::MODE_KERNEL)
            && ((newMode < curMode) || (psChk != '0));
        newSp = (spReg + srcc_pkg::FRAME_BYTES)
            | {58'h0, newPs[srcc_pkg::ALIGN_LSB +: srcc_pkg::ALIGN_W]};
    end

    // ------------------------------------------------------------
    // operation sequencer
    // ------------------------------------------------------------
    always_comb begin
        stateNext = stateReg;
        popIdxNext = popIdxReg;
        tmpNext = tmpReg;
        psNext = psReg;
        spNext = spReg;
        teNext = teReg;
        lockNext = lockReg;
        hdlNext = hdlReg;
        memReqNext = memReqReg;
        memAddrNext = memAddrReg;
        gprWeNext = 1'b0;
        gprIdxNext = gprIdxReg;
        gprDataNext = gprDataReg;
        pcLoadNext = 1'b0;
        pcNext = pcReg;
        doneNext = 1'b0;
        illNext = 1'b0;
        intTakeNext = 1'b0;
        astTakeNext = 1'b0;
        slotWe = 1'b0;
        sccRd = 1'b0;
        if (spWe && (stateReg == srcc_pkg::ST_IDLE)) begin
            spNext = spWdata;
        end
        case (stateReg)
            srcc_pkg::ST_IDLE: begin
                if (opValid) begin
                    doneNext = (opCode != srcc_pkg::OP_REI);
                    gprWeNext = (opCode != srcc_pkg::OP_REI)
                        && (opCode != srcc_pkg::OP_WR_SW);
                    gprIdxNext = srcc_pkg::GPR_RESULT;
                    case (opCode)
                        srcc_pkg::OP_READ_STATUS_OP: begin
                            // alignment lives only on the stack: reads zero
                            gprDataNext = {51'h0, psReg};
                        end
                        srcc_pkg::OP_READ_SYSTEM_CYCLES: begin
                            sccRd = 1'b1;
                            gprDataNext = cycleReadDisable ? '0
                                : sccValue;
                        end
                        srcc_pkg::OP_READ_PROCESS_CYCLES: begin
                            gprDataNext = cycleReadDisable ? '0
                                : {32'h0, pccLow};
                        end
                        srcc_pkg::OP_SWAP_TE: begin
                            gprDataNext = {63'h0, teReg[curMode]};
                            teNext[curMode] = r16[0];
                            astTakeNext = astPending[curMode]
                                & r16[0];
                        end
                        srcc_pkg::OP_WR_SW: begin
                            psNext[srcc_pkg::SW_LSB +: srcc_pkg::SW_W] =
                                r16[1:0];
                        end
                        srcc_pkg::OP_REI: begin
                            if (spReg[5:0] != 6'h00) begin
                                illNext = 1'b1;
                                doneNext = 1'b1;
                            end else begin
                                stateNext = srcc_pkg::ST_POP;
                                popIdxNext = 3'h0;
                                memReqNext = 1'b1;
                                memAddrNext = spReg;
                            end
                        end
                        default: begin
                            gprWeNext = 1'b0;
                        end
                    endcase
                end
            end
            srcc_pkg::ST_POP: begin
                if (memAck) begin
                    tmpNext[popIdxReg] = memData;
                    popIdxNext = popIdxReg + 3'h1;
                    memAddrNext = memAddrReg + srcc_pkg::QW_BYTES;
                    if (popIdxReg == srcc_pkg::IDX_PS) begin
                        memReqNext = 1'b0;
                        stateNext = srcc_pkg::ST_CHECK;
                    end
                end
            end
            srcc_pkg::ST_CHECK: begin
                if (badPs) begin
                    // nothing committed yet, so a reject is clean
                    illNext = 1'b1;
                    doneNext = 1'b1;
                    stateNext = srcc_pkg::ST_IDLE;
                end else begin
                    slotWe = 1'b1;
                    spNext = (newMode == curMode) ? newSp : slotRd;
                    psNext = newPs[12:0];
                    lockNext = 1'b0;
                    hdlNext = 1'b0;
                    popIdxNext = 3'h0;
                    stateNext = srcc_pkg::ST_WB;
                end
            end
            srcc_pkg::ST_WB: begin
                gprWeNext = 1'b1;
                gprIdxNext = srcc_pkg::GPR_FIRST + popIdxReg;
                gprDataNext = tmpReg[popIdxReg];
                popIdxNext = popIdxReg + 3'h1;
                if (popIdxReg == 3'(srcc_pkg::GPR_CNT - 1)) begin
                    stateNext = srcc_pkg::ST_DONE;
                end
            end
            srcc_pkg::ST_DONE: begin
                pcLoadNext = 1'b1;
                pcNext = tmpReg[srcc_pkg::IDX_PC];
                doneNext = 1'b1;
                intTakeNext = intPending;
                astTakeNext = astPending[curMode] & teReg[curMode];
                stateNext = srcc_pkg::ST_IDLE;
            end
            default: begin
                stateNext = srcc_pkg::ST_IDLE;
            end
        endcase
        // a set arriving with the return's clear is kept
        if (lockSet) begin
            lockNext = 1'b1;
        end
        if (handlerSet) begin
            hdlNext = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stateReg <= srcc_pkg::ST_IDLE;
            popIdxReg <= 3'h0;
            for (int i = 0; i < srcc_pkg::POP_CNT; i++) begin
                tmpReg[i] <= '0;
            end
            psReg <= srcc_pkg::PS_RESET;
            spReg <= '0;
            teReg <= srcc_pkg::TE_RESET;
            lockReg <= 1'b0;
            hdlReg <= 1'b0;
            memReqReg <= 1'b0;
            memAddrReg <= '0;
            gprWeReg <= 1'b0;
            gprIdxReg <= 3'h0;
            gprDataReg <= '0;
            pcLoadReg <= 1'b0;
            pcReg <= '0;
            doneReg <= 1'b0;
            illReg <= 1'b0;
            intTakeReg <= 1'b0;
            astTakeReg <= 1'b0;
        end else if (ce) begin
            stateReg <= stateNext;
            popIdxReg <= popIdxNext;
            tmpReg <= tmpNext;
            psReg <= psNext;
            spReg <= spNext;
            teReg <= teNext;
            lockReg <= lockNext;
            hdlReg <= hdlNext;
            memReqReg <= memReqNext;
            memAddrReg <= memAddrNext;
            gprWeReg <= gprWeNext;
            gprIdxReg <= gprIdxNext;
            gprDataReg <= gprDataNext;
            pcLoadReg <= pcLoadNext;
            pcReg <= pcNext;
            doneReg <= doneNext;
            illReg <= illNext;
            intTakeReg <= intTakeNext;
            astTakeReg <= astTakeNext;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign opReady = (stateReg == srcc_pkg::ST_IDLE);
    assign opDone = doneReg;
    assign illegalOperand = illReg;
    assign gprWe = gprWeReg;
    assign gprIdx = gprIdxReg;
    assign gprData = gprDataReg;
    assign pcLoad = pcLoadReg;
    assign pcOut = pcReg;
    assign psOut = psReg;
    assign spOut = spReg;
    assign memReq = memReqReg;
    assign memAddr = memAddrReg;
    assign trapEnOut = teReg;
    assign intTake = intTakeReg;
    assign astTake = astTakeReg;
    assign lockFlag = lockReg;
    assign handlerFlag = hdlReg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence seqTake(srcc_pkg::srcc_op_t op);
        ce && opValid && opReady && (opCode == op);
    endsequence
    sequence seqCheckPass;
        ce && (stateReg == srcc_pkg::ST_CHECK) && !badPs;
    endsequence
    sequence seqRestoreStep(logic [2:0] idx);
        gprWe && (gprIdx == idx);
    endsequence

    AST_READ_STATUS_OP_ZERO_ALIGN: assert property (
        seqTake(srcc_pkg::OP_READ_STATUS_OP) |=> gprWe && (gprIdx == 3'h0)
            && (gprData == {51'h0, $past(psReg)}))
    else $error("status read returned wrong value");
    AST_MISALIGN_FAULT: assert property (
        (seqTake(srcc_pkg::OP_REI) and (spReg[5:0] != 6'h00))
            |=> illegalOperand && opDone && !memReq)
    else $error("misaligned return not faulted");
    AST_POP_ADDR: assert property (
        (stateReg == srcc_pkg::ST_POP) |->
            memAddr == spReg + {58'h0, popIdxReg, 3'h0})
    else $error("pop address out of order");
    AST_PRIV_CHECK: assert property (
        ce && (stateReg == srcc_pkg::ST_CHECK) && badPs
            |=> illegalOperand && opDone && opReady)
    else $error("invalid new status accepted");
    AST_NEW_SP: assert property (
        (seqCheckPass and (newMode == curMode))
            |=> spReg == $past(newSp))
    else $error("stack pointer not rebuilt");
    AST_FLAGS_CLEAR: assert property (
        (seqCheckPass and (!lockSet && !handlerSet))
            |=> !lockFlag && !handlerFlag)
    else $error("return left flags set");
    AST_RESTORE_SEQ: assert property (
        // first restore write shows two edges after the check
        seqCheckPass |=> ##1 seqRestoreStep(3'h2)
            ##1 seqRestoreStep(3'h3))
    else $error("register restore not started");
    AST_FAIL_KEEPS: assert property (
        illegalOperand |-> $stable(spReg) && $stable(psReg) && !gprWe)
    else $error("failed return modified state");
    AST_SCC_DISABLE: assert property (
        seqTake(srcc_pkg::OP_READ_SYSTEM_CYCLES) && cycleReadDisable
            |=> gprData == 64'h0)
    else $error("disabled cycle read not zero");
    AST_SWAP_TE: assert property (
        seqTake(srcc_pkg::OP_SWAP_TE) |=>
            (gprData == {63'h0, $past(teReg[curMode])})
            && (teReg[$past(curMode)] == $past(r16[0])))
    else $error("trap enable swap wrong");
    AST_WR_SW: assert property (
        seqTake(srcc_pkg::OP_WR_SW) |=> (psReg[1:0] == $past(r16[1:0]))
            && (psReg[12:2] == $past(psReg[12:2])))
    else $error("software field write wrong");
    AST_NO_EXC: assert property (
        ce && opValid && opReady && (opCode != srcc_pkg::OP_REI)
            |=> opDone && !illegalOperand)
    else $error("simple operation raised exception");
    AST_INT_AFTER_REI: assert property (
        ce && (stateReg == srcc_pkg::ST_DONE) && intPending
            |=> intTake && pcLoad)
    else $error("pending interrupt not taken");
endmodule

// [tb/srcc_mem_model.sv]
// stack memory that answers the unit's quadword reads
// assumes sp is 64-byte aligned, so addr[5:3] is the frame slot
`timescale 1ns/100ps
module srcc_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic [63:0] psWord,
    input wire logic memReq,
    input wire logic [63:0] memAddr,
    output logic memAck,
    output logic [63:0] memData
);
    logic [1:0] waitReg;
    // ------------------------------------------------
    // read answer
    // ------------------------------------------------
    // whole stack readable from every mode; the model has no write port
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            memAck <= 1'b0;
            memData <= 64'h0;
            waitReg <= 2'h0;
        end else begin
            memAck <= 1'b0;
            // bus not answering toggles, never holds the last word
            memData <= ~memData;
            if (memReq && !memAck) begin
                if (!slow || waitReg == 2'h3) begin
                    memAck <= 1'b1;
                    memData <= (memAddr[5:3] == 3'h7) ? psWord : ~memAddr;
                    waitReg <= 2'h0;
                end else begin
                    waitReg <= waitReg + 2'h1;
                end
            end
        end
    end
endmodule

// [tb/testbench.sv]
// op-level tests of the status, return and cycle counter unit
// assumes the memory model answers the stack reads
`timescale 1ns/100ps
`define CHK(n, e, g) chk(n, e, g)
module testbench;
    logic clk = 1'b0, rst = 1'b1, opValid = 1'b0, spWe = 1'b0, slow = 1'b0;
    logic intPending = 1'b0, lockSet = 1'b0, handlerSet = 1'b0;
    logic clockIrq = 1'b0, cycleReadDisable = 1'b0, ce = 1'b1;
    srcc_pkg::srcc_op_t opCode = srcc_pkg::OP_READ_STATUS_OP;
    logic [63:0] r16 = 64'h0, spWdata = 64'h0, psWord = 64'h0;
    logic [3:0] astPending = 4'h0;
    logic opReady, opDone, illegalOperand, gprWe, pcLoad, memReq, memAck;
    logic intTake, astTake, lockFlag, handlerFlag;
    logic [2:0] gprIdx;
    logic [63:0] gprData, pcOut, spOut, memAddr, memData, res, pcSeen;
    logic [63:0] gpr [0:7];
    logic [12:0] psOut;
    logic [3:0] trapEnOut;
    logic ill, intSeen, astSeen;
    int bad_count = 0, check_count = 0;
    always #20 clk = ~clk;
    srcc_status_unit dut_u (.clk(clk), .rst(rst), .ce(ce),
        .opValid(opValid), .opCode(opCode), .r16(r16), .opReady(opReady),
        .opDone(opDone), .illegalOperand(illegalOperand), .gprWe(gprWe),
        .gprIdx(gprIdx), .gprData(gprData), .pcLoad(pcLoad), .pcOut(pcOut),
        .psOut(psOut), .spOut(spOut), .spWe(spWe), .spWdata(spWdata),
        .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
        .memData(memData), .intPending(intPending),
        .astPending(astPending), .trapEnOut(trapEnOut), .intTake(intTake),
        .astTake(astTake), .lockSet(lockSet), .handlerSet(handlerSet),
        .lockFlag(lockFlag), .handlerFlag(handlerFlag),
        .clockIrq(clockIrq), .cycleReadDisable(cycleReadDisable));
    srcc_mem_model mem_u (.clk(clk), .rst(rst), .slow(slow),
        .psWord(psWord), .memReq(memReq), .memAddr(memAddr),
        .memAck(memAck), .memData(memData));
    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task automatic chk(input string n, input logic [63:0] e,
        input logic [63:0] g);
        check_count++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic set_sp(input logic [63:0] v);
        spWe = 1'b1;
        spWdata = v;
        @(negedge clk);
        spWe = 1'b0;
    endtask
    // one op, recording every pulse until opDone
    task automatic run_op(input srcc_pkg::srcc_op_t c, input logic [63:0] v);
        int n;
        foreach (gpr[i]) gpr[i] = 'x;
        {ill, intSeen, astSeen} = 3'h0;
        opValid = 1'b1;
        opCode = c;
        r16 = v;
        @(negedge clk);
        opValid = 1'b0;
        // pulses of the done cycle itself are recorded before leaving
        for (n = 0; n < 300; n++) begin
            if (gprWe === 1'b1) gpr[gprIdx] = gprData;
            if (pcLoad === 1'b1) pcSeen = pcOut;
            ill |= illegalOperand;
            intSeen |= intTake;
            astSeen |= astTake;
            if (opDone === 1'b1) break;
            @(negedge clk);
        end
        if (n == 300) begin
            bad_count++;
            report_and_stop();
        end
        res = gpr[0];
    endtask
    // ------------------------------------------------
    // tests
    // ------------------------------------------------
    initial begin
        logic [63:0] v1;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        run_op(srcc_pkg::OP_READ_SYSTEM_CYCLES, 64'h0);
        `CHK("count start", res, 64'h0);
        v1 = res;
        clockIrq = 1'b1;
        @(negedge clk);
        clockIrq = 1'b0;
        run_op(srcc_pkg::OP_READ_SYSTEM_CYCLES, 64'h0);
        `CHK("count rises", res > v1, 1'b1);
        v1 = res;
        ce = 1'b0;
        repeat (20) @(negedge clk);
        ce = 1'b1;
        run_op(srcc_pkg::OP_READ_SYSTEM_CYCLES, 64'h0);
        `CHK("frozen count", res, v1 + 64'h1);
        run_op(srcc_pkg::OP_READ_PROCESS_CYCLES, 64'h0);
        `CHK("proc upper", res[63:32], 32'h0);
        cycleReadDisable = 1'b1;
        for (int k = 2; k < 4; k++) begin
            run_op(srcc_pkg::srcc_op_t'(k), 64'h0);
            `CHK("disabled read", res, 64'h0);
        end
        cycleReadDisable = 1'b0;
        $display("test cycle counter done");
        run_op(srcc_pkg::OP_WR_SW, 64'hfffd);
        `CHK("sw field", psOut, 13'h0001);
        run_op(srcc_pkg::OP_READ_STATUS_OP, 64'h0);
        `CHK("status read", res, 64'h1);
        `CHK("no fault", ill, 1'b0);
        astPending = 4'h1;
        run_op(srcc_pkg::OP_SWAP_TE, 64'h3);
        `CHK("old enable", res, 64'h0);
        `CHK("enables", trapEnOut, 4'h1);
        `CHK("trap taken", astSeen, 1'b1);
        run_op(srcc_pkg::OP_SWAP_TE, 64'h2);
        `CHK("old enable", res, 64'h1);
        `CHK("no trap", astSeen, 1'b0);
        astPending = 4'h0;
        $display("test status ops done");
        set_sp(64'h1008);
        run_op(srcc_pkg::OP_REI, 64'h0);
        `CHK("misaligned", ill, 1'b1);
        `CHK("sp kept", spOut, 64'h1008);
        `CHK("ps kept", psOut, 13'h0001);
        set_sp(64'h1000);
        {lockSet, handlerSet, slow, intPending} = 4'hf;
        @(negedge clk);
        {lockSet, handlerSet} = 2'h0;
        `CHK("lock set", lockFlag, 1'b1);
        // stays in kernel, so ipl may be nonzero
        psWord = 64'h0500_0000_0000_0002;
        run_op(srcc_pkg::OP_REI, 64'h0);
        `CHK("good return", ill, 1'b0);
        for (int i = 2; i < 8; i++) begin
            `CHK("restored gpr", gpr[i], ~(64'h1000 + 8 * (i - 2)));
        end
        `CHK("new pc", pcSeen, ~64'h1030);
        `CHK("new ps", psOut, 13'h0002);
        `CHK("new sp", spOut, 64'h1045);
        `CHK("flags", {lockFlag, handlerFlag}, 2'h0);
        `CHK("int taken", intSeen, 1'b1);
        {slow, intPending} = 2'h0;
        set_sp(64'h2000);
        psWord = 64'h18;
        run_op(srcc_pkg::OP_REI, 64'h0);
        `CHK("user sp slot", spOut, 64'h0);
        `CHK("user ps", psOut, 13'h0018);
        `CHK("no int", intSeen, 1'b0);
        set_sp(64'h3000);
        for (int j = 0; j < 2; j++) begin
            psWord = j ? 64'h98 : 64'h0;
            run_op(srcc_pkg::OP_REI, 64'h0);
            `CHK("bad ps", ill, 1'b1);
            `CHK("ps kept", psOut, 13'h0018);
            `CHK("sp kept", spOut, 64'h3000);
            `CHK("gpr kept", gpr[2], 64'hx);
        end
        $display("test return done");
        report_and_stop();
    end
endmodule
